// File: rtl/socket_sig.sv
// Socket-side signalling of a PC Card / CardBus host controller.
// Behaviour
// - Memory read drives the output-enable strobe low.
// - Memory write drives the write-enable strobe low.
// - I/O read drives the I/O read strobe low.
// - I/O write drives the I/O write strobe low.
// - Memory mode reports the shared pin as write-protect status.
// - I/O mode uses the shared pin, low, to make the access 16 bits.
// - CardBus mode runs the card clock only while the clock-run pin is low.
// - Memory mode reports the ready pin as ready or busy.
// - I/O mode reports the ready pin, low, as card interrupt request.
// - CardBus interrupt is pending exactly while its pin is low.
// - A low wait pin stalls the strobe until it goes high.
// - Both card-detect pins low mean a card is present; in CardBus mode the code takes either pin low as seated.
// - CardBus presence and type come from detect and voltage-sense pins.
// - Card enable one selects even bytes, card enable two odd bytes.
// - In 8-bit configuration only card enable one is used, with A0.
// - In 16-bit modes card reset is low normally, high to reset.
// - Card reset is undriven unless card seated, powered and enabled.
// - In CardBus mode the reset pin is the active-low card reset.
// - Memory mode reports the audio pin as battery warning.
// - I/O mode may take the audio pin as speaker input.
// - The audio pin may be the drive LED; CardBus takes it as audio.
// - CardBus mode releases all 16-bit strobes and enables to other use.
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "socket_sig_regs.svh"
module socket_sig
  import socket_sig_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic CD1_B,
  input wire logic CD2_B,
  input wire logic VS1,
  input wire logic VS2,
  input wire logic WP_PIN,
  input wire logic READY_PIN,
  input wire logic WAIT_B,
  input wire logic BVD2_PIN,
  input wire logic [15:0] D_IN,
  output logic [15:0] D_OUT,
  output logic D_OE,
  output logic OE_B,
  output logic WE_B,
  output logic IORD_B,
  output logic IOWR_B,
  output logic CE1_B,
  output logic CE2_B,
  output logic A0,
  output logic CTL_OE,
  output logic CARD_RESET,
  output logic CARD_RESET_OE,
  output logic CCLK,
  output logic SPKR_OUT,
  output logic LED_OUT
);

  typedef struct packed {
    logic [23:0] s1;
    logic [23:0] s2;
    logic [7:0] ctrl;
    acc_e st;
    logic [3:0] cnt;
    logic wr;
    logic io;
    logic wide;
    logic [15:0] rdata;
    logic [31:0] dat;
    logic ack;
    logic [15:0] dout;
    logic doe;
    logic oe_b;
    logic we_b;
    logic iord_b;
    logic iowr_b;
    logic ce1_b;
    logic ce2_b;
    logic a0;
    logic ctl_oe;
    logic rst;
    logic rst_oe;
    logic cclk;
    logic spkr;
    logic led;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic cd1_s, cd2_s, vs1_s, vs2_s, wp_s, rdy_s, wait_s, bvd2_s;
  logic [15:0] din_s;
  mode_e mode;
  bfn_e bfn;
  logic present, seated, wp_stat, ireq, cint, iois16, warn, audio;
  logic [15:0] status;

  assign {cd1_s, cd2_s, vs1_s, vs2_s, wp_s, rdy_s, wait_s, bvd2_s, din_s} = st_reg.s2;
  assign mode = mode_e'(st_reg.ctrl[`CTRL_MODE]);
  assign bfn = bfn_e'(st_reg.ctrl[`CTRL_BFN]);

  function automatic logic cb_mode(input mode_e m);
    cb_mode = (m == MODE_CB);
  endfunction

  always_comb begin
    present = !cd1_s && !cd2_s;
    seated = cb_mode(mode) ? (!cd1_s || !cd2_s) : present;
    wp_stat = (mode == MODE_MEM) && wp_s;
    iois16 = (mode == MODE_IO) && !wp_s;
    ireq = (mode == MODE_IO) && !rdy_s;
    cint = cb_mode(mode) && !rdy_s;
    warn = (mode == MODE_MEM) && !bvd2_s;
    audio = cb_mode(mode) && bvd2_s;
    status = {vs2_s, vs1_s, cd2_s, cd1_s, st_reg.wide, iois16, audio,
              st_reg.led, st_reg.spkr, warn, cint, ireq,
              (mode == MODE_MEM) && rdy_s, wp_stat, seated,
              st_reg.st != ST_IDLE};
  end

  always_comb begin
    st_next = st_reg;
    st_next.s1 = {CD1_B, CD2_B, VS1, VS2, WP_PIN, READY_PIN, WAIT_B, BVD2_PIN, D_IN};
    st_next.s2 = st_reg.s1;
    st_next.ack = CYC_I && STB_I && !st_reg.ack;
    if (CYC_I && STB_I && !st_reg.ack) begin
      case (ADR_I)
        `CTRL_OFS: st_next.dat = {24'h000000, st_reg.ctrl};
        `STAT_OFS: st_next.dat = {16'h0000, status};
        `RDATA_OFS: st_next.dat = {16'h0000, st_reg.rdata};
        default: st_next.dat = 32'h00000000;
      endcase
    end
    if (CYC_I && STB_I && st_reg.ack && WE_I) begin
      if (ADR_I == `CTRL_OFS && SEL_I[0]) begin
        st_next.ctrl = DAT_I[7:0];
      end
      if (ADR_I == `CMD_OFS && st_reg.st == ST_IDLE && !cb_mode(mode)) begin
        st_next.wr = DAT_I[`CMD_WR];
        st_next.io = DAT_I[`CMD_IO];
        st_next.a0 = DAT_I[`CMD_A0];
        st_next.dout = DAT_I[`CMD_WDATA];
        st_next.st = ST_SETUP;
      end
    end
    case (st_reg.st)
      ST_IDLE: begin
        st_next.doe = 1'b0;
        st_next.ce1_b = 1'b1;
        st_next.ce2_b = 1'b1;
      end
      ST_SETUP: begin
        st_next.wide = !st_reg.ctrl[`CTRL_BUS8] && (!st_reg.io || iois16);
        st_next.ce1_b = 1'b0;
        st_next.ce2_b = st_reg.ctrl[`CTRL_BUS8] || (st_reg.io && !iois16);
        st_next.doe = st_reg.wr;
        st_next.oe_b = !(!st_reg.io && !st_reg.wr);
        st_next.we_b = !(!st_reg.io && st_reg.wr);
        st_next.iord_b = !(st_reg.io && !st_reg.wr);
        st_next.iowr_b = !(st_reg.io && st_reg.wr);
        st_next.cnt = 4'h1;
        st_next.st = ST_STROBE;
      end
      ST_STROBE: begin
        if (st_reg.cnt < 4'(`STROBE_CYC)) begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end else if (wait_s) begin
          if (!st_reg.wr) begin
            st_next.rdata = st_reg.wide ? din_s : {8'h00, din_s[7:0]};
          end
          st_next.oe_b = 1'b1;
          st_next.we_b = 1'b1;
          st_next.iord_b = 1'b1;
          st_next.iowr_b = 1'b1;
          st_next.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        st_next.ce1_b = 1'b1;
        st_next.ce2_b = 1'b1;
        st_next.doe = 1'b0;
        st_next.st = ST_IDLE;
      end
      default: st_next.st = ST_IDLE;
    endcase
    st_next.ctl_oe = !cb_mode(mode) && st_reg.ctrl[`CTRL_IFEN];
    st_next.rst_oe = seated && st_reg.ctrl[`CTRL_PWR] && st_reg.ctrl[`CTRL_IFEN];
    st_next.rst = cb_mode(mode) ? !st_reg.ctrl[`CTRL_CRST]
                                : st_reg.ctrl[`CTRL_CRST];
    st_next.cclk = (cb_mode(mode) && !wp_s) ? !st_reg.cclk : 1'b0;
    st_next.spkr = (mode == MODE_IO) && (bfn == BFN_SPKR) && !bvd2_s;
    st_next.led = !cb_mode(mode) && (bfn == BFN_LED) && !bvd2_s;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg <= '0;
      st_reg.s1 <= 24'hFFFFFF;
      st_reg.s2 <= 24'hFFFFFF;
      st_reg.ctrl <= `CTRL_RST;
      st_reg.st <= ST_IDLE;
      st_reg.oe_b <= 1'b1;
      st_reg.we_b <= 1'b1;
      st_reg.iord_b <= 1'b1;
      st_reg.iowr_b <= 1'b1;
      st_reg.ce1_b <= 1'b1;
      st_reg.ce2_b <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign DAT_O = st_reg.dat;
  assign ACK_O = st_reg.ack;
  assign D_OUT = st_reg.dout;
  assign D_OE = st_reg.doe;
  assign OE_B = st_reg.oe_b;
  assign WE_B = st_reg.we_b;
  assign IORD_B = st_reg.iord_b;
  assign IOWR_B = st_reg.iowr_b;
  assign CE1_B = st_reg.ce1_b;
  assign CE2_B = st_reg.ce2_b;
  assign A0 = st_reg.a0;
  assign CTL_OE = st_reg.ctl_oe;
  assign CARD_RESET = st_reg.rst;
  assign CARD_RESET_OE = st_reg.rst_oe;
  assign CCLK = st_reg.cclk;
  assign SPKR_OUT = st_reg.spkr;
  assign LED_OUT = st_reg.led;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  property p_oe_read;
    !OE_B |-> (!st_reg.io && !st_reg.wr && !CE1_B && WE_B);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("OE low outside memory read.");

  property p_we_write;
    !WE_B |-> (!st_reg.io && st_reg.wr && !CE1_B && D_OE);
  endproperty
  a_we_write: assert property (p_we_write) else $error("WE low outside memory write.");

  property p_iord;
    $fell(IORD_B) |-> st_reg.io && !st_reg.wr && $past(st_reg.st) == ST_SETUP;
  endproperty
  a_iord: assert property (p_iord) else $error("IORD fell without an I/O read.");

  property p_iowr;
    !IOWR_B |-> (st_reg.io && st_reg.wr && OE_B && IORD_B);
  endproperty
  a_iowr: assert property (p_iowr) else $error("IOWR low outside I/O write.");

  property p_strobe_min;
    $fell(OE_B) |-> !OE_B [*3];
  endproperty
  a_strobe_min: assert property (p_strobe_min) else $error("Strobe shorter than minimum.");

  property p_wait_stall;
    (st_reg.st == ST_STROBE && !wait_s) |=> st_reg.st == ST_STROBE;
  endproperty
  a_wait_stall: assert property (p_wait_stall) else $error("Cycle ended while wait low.");

  property p_bus8;
    (st_reg.ctrl[`CTRL_BUS8] && st_reg.st == ST_STROBE) |-> CE2_B && !CE1_B;
  endproperty
  a_bus8: assert property (p_bus8) else $error("CE2 used in 8-bit mode.");

  property p_rst_oe;
    CARD_RESET_OE |-> $past(st_reg.ctrl[`CTRL_PWR]) && $past(st_reg.ctrl[`CTRL_IFEN]);
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("Reset driven while unpowered.");

  property p_cclk_stop;
    (!cb_mode(mode) || wp_s) |=> !CCLK;
  endproperty
  a_cclk_stop: assert property (p_cclk_stop) else $error("Card clock ran while stopped.");

  property p_cb_quiet;
    cb_mode(mode) |=> !CTL_OE;
  endproperty
  a_cb_quiet: assert property (p_cb_quiet) else $error("16-bit pins driven in CardBus.");

  property p_ack_pulse;
    ACK_O |=> !ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Acknowledge longer than one cycle.");

  property p_spkr_on;
    (mode == MODE_IO && bfn == BFN_SPKR && !bvd2_s) |=> SPKR_OUT;
  endproperty
  a_spkr_on: assert property (p_spkr_on) else $error("Speaker input not passed.");

  property p_led_on;
    (!cb_mode(mode) && bfn == BFN_LED && !bvd2_s) |=> LED_OUT;
  endproperty
  a_led_on: assert property (p_led_on) else $error("LED input not passed.");

  property p_cb_aux;
    cb_mode(mode) |=> !LED_OUT && !SPKR_OUT;
  endproperty
  a_cb_aux: assert property (p_cb_aux) else $error("Aux outputs set in CardBus.");

  property p_rst_16;
    !cb_mode(mode) |=> CARD_RESET == $past(st_reg.ctrl[`CTRL_CRST]);
  endproperty
  a_rst_16: assert property (p_rst_16) else $error("Card reset not control bit.");

  property p_rst_cb;
    cb_mode(mode) |=> CARD_RESET == !$past(st_reg.ctrl[`CTRL_CRST]);
  endproperty
  a_rst_cb: assert property (p_rst_cb) else $error("CardBus reset not inverted.");

  property p_cd_both;
    (!cb_mode(mode) && (cd1_s || cd2_s)) |=> !CARD_RESET_OE;
  endproperty
  a_cd_both: assert property (p_cd_both) else $error("Reset driven, card absent.");

  property p_ce_idle;
    st_reg.st inside {ST_IDLE, ST_SETUP} |-> CE1_B && CE2_B && OE_B && WE_B && IORD_B && IOWR_B;
  endproperty
  a_ce_idle: assert property (p_ce_idle) else $error("Enable or strobe low idle.");

  property p_ce_strb;
    st_reg.st == ST_STROBE |-> !CE1_B;
  endproperty
  a_ce_strb: assert property (p_ce_strb) else $error("CE1 high during strobe.");

  property p_io_narrow;
    (mode == MODE_IO && st_reg.st == ST_SETUP && st_reg.io && wp_s) |=> CE2_B;
  endproperty
  a_io_narrow: assert property (p_io_narrow) else $error("8-bit I/O used CE2.");

  property p_cb_idle;
    (cb_mode(mode) && st_reg.st == ST_IDLE) |=> st_reg.st == ST_IDLE;
  endproperty
  a_cb_idle: assert property (p_cb_idle) else $error("Access started in CardBus.");

  property p_cclk_run;
    (cb_mode(mode) && !wp_s) |=> CCLK != $past(CCLK);
  endproperty
  a_cclk_run: assert property (p_cclk_run) else $error("Card clock not toggling.");

  property p_rd_float;
    (!OE_B || !IORD_B) |-> !D_OE;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("Data driven in a read.");

  property p_iord_min;
    $fell(IORD_B) |-> !IORD_B [*3];
  endproperty
  a_iord_min: assert property (p_iord_min) else $error("IORD shorter than minimum.");

  property p_ctl_on;
    (!cb_mode(mode) && st_reg.ctrl[`CTRL_IFEN]) |=> CTL_OE;
  endproperty
  a_ctl_on: assert property (p_ctl_on) else $error("Control pins not enabled.");

  c_mem_read: cover property ($fell(OE_B) ##[1:20] $rose(OE_B));
  c_io_write: cover property ($fell(IOWR_B) ##[1:20] $rose(IOWR_B));
  c_io_read: cover property ($fell(IORD_B) ##[1:20] $rose(IORD_B));
  c_wait: cover property (st_reg.st == ST_STROBE && !wait_s ##1 !wait_s);
  c_cb_clk: cover property (cb_mode(mode) && $rose(CCLK));

endmodule // socket_sig
`default_nettype wire

// File: rtl/socket_sig_pkg.sv
// Types shared by the socket signalling block.
`default_nettype none
package socket_sig_pkg;
  typedef enum logic [1:0] {MODE_MEM, MODE_IO, MODE_CB, MODE_RSV} mode_e;
  typedef enum logic [1:0] {BFN_NONE, BFN_SPKR, BFN_LED, BFN_RSV} bfn_e;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} acc_e;
endpackage
`default_nettype wire

// File: rtl/socket_sig_regs.svh
// Register offsets, fields, reset values and timing counts of the socket block.
`ifndef SOCKET_SIG_REGS_SVH
`define SOCKET_SIG_REGS_SVH
`define CTRL_OFS 4'h0
`define CMD_OFS 4'h4
`define STAT_OFS 4'h8
`define RDATA_OFS 4'hC
`define CTRL_RST 8'h08
`define CTRL_MODE 1:0
`define CTRL_BUS8 2
`define CTRL_CRST 3
`define CTRL_PWR 4
`define CTRL_IFEN 5
`define CTRL_BFN 7:6
`define CMD_WDATA 15:0
`define CMD_WR 16
`define CMD_IO 17
`define CMD_A0 18
`define CLK_MHZ 20
`define STROBE_NS 150
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`endif

// File: sim/card_model.sv
// Behavioural card in the socket: data store and wait-state insertion.
`timescale 1ns/10ps
`default_nettype none
module card_model (
  input wire logic CLK,
  input wire logic OE_B,
  input wire logic WE_B,
  input wire logic IORD_B,
  input wire logic IOWR_B,
  input wire logic [15:0] D_OUT,
  input wire logic [3:0] wait_len,
  output logic WAIT_B,
  output logic [15:0] D_IN
);
  logic [15:0] store = 16'hA55A;
  logic [3:0] wcnt = 4'h0;
  logic act_q = 1'b0;
  logic rd;
  logic wr;
  assign rd = !OE_B || !IORD_B;
  assign wr = !WE_B || !IOWR_B;
  // A released data bus shows the inverse of the stored word.
  assign D_IN = rd ? store : ~store;
  // Wait falls with the strobe itself, so the host's two-flop sampling still catches it.
  assign WAIT_B = (wcnt == 4'h0) && !((rd || wr) && !act_q && (wait_len != 4'h0));
  always @(posedge CLK) begin
    act_q <= rd || wr;
    if ((rd || wr) && !act_q) begin
      wcnt <= wait_len;
    end else if (wcnt != 4'h0) begin
      wcnt <= wcnt - 4'h1;
    end
    if (wr) begin
      store <= D_OUT;
    end
  end
endmodule // card_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for register, card access and pin meaning scenarios.
`timescale 1ns/10ps
`default_nettype none
`include "socket_sig_regs.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module testbench;
  logic CLK = 1'b0, RST_B = 1'b0, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
  logic [3:0] ADR_I = 4'h0, SEL_I = 4'hF, wait_len = 4'h0, strb;
  logic [31:0] DAT_I = 32'h0, DAT_O, q;
  logic CD1_B = 1'b0, CD2_B = 1'b0, VS1 = 1'b1, VS2 = 1'b0;
  logic WP_PIN = 1'b0, READY_PIN = 1'b1, BVD2_PIN = 1'b1, c, a0s, doe_s;
  logic ACK_O, D_OE, OE_B, WE_B, IORD_B, IOWR_B, CE1_B, CE2_B, A0, CTL_OE;
  logic CARD_RESET, CARD_RESET_OE, CCLK, SPKR_OUT, LED_OUT, WAIT_B;
  logic [15:0] D_IN, D_OUT;
  logic [1:0] ces;
  int num_errors = 0, checks = 0, last_len = 0, lowcnt = 0;
  socket_sig u_dut (.CLK(CLK), .RST_B(RST_B), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .CD1_B(CD1_B), .CD2_B(CD2_B), .VS1(VS1), .VS2(VS2), .WP_PIN(WP_PIN),
    .READY_PIN(READY_PIN), .WAIT_B(WAIT_B), .BVD2_PIN(BVD2_PIN), .D_IN(D_IN),
    .D_OUT(D_OUT), .D_OE(D_OE), .OE_B(OE_B), .WE_B(WE_B), .IORD_B(IORD_B),
    .IOWR_B(IOWR_B), .CE1_B(CE1_B), .CE2_B(CE2_B), .A0(A0), .CTL_OE(CTL_OE),
    .CARD_RESET(CARD_RESET), .CARD_RESET_OE(CARD_RESET_OE), .CCLK(CCLK),
    .SPKR_OUT(SPKR_OUT), .LED_OUT(LED_OUT));
  card_model u_card (.CLK(CLK), .OE_B(OE_B), .WE_B(WE_B), .IORD_B(IORD_B),
    .IOWR_B(IOWR_B), .D_OUT(D_OUT), .wait_len(wait_len), .WAIT_B(WAIT_B), .D_IN(D_IN));
  initial forever #25 CLK = ~CLK;
  always @(posedge CLK) begin
    if (!(OE_B && WE_B && IORD_B && IOWR_B)) begin
      lowcnt <= lowcnt + 1;
      strb <= {OE_B, WE_B, IORD_B, IOWR_B};
      ces <= {CE1_B, CE2_B};
      a0s <= A0;
      doe_s <= D_OE;
    end else if (lowcnt != 0) begin
      last_len <= lowcnt;
      lowcnt <= 0;
    end
  end
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] b,
    input logic r, input logic e8);
    return {24'h0, b, 2'b11, r, e8, m};
  endfunction
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge CLK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= d;
    do @(posedge CLK); while (ACK_O !== 1'b1);
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask
  // Pin order is write-protect, ready, audio, detect one; inputs pass two flops.
  task automatic pins(input logic [3:0] v);
    {WP_PIN, READY_PIN, BVD2_PIN, CD1_B} <= v;
    repeat (5) @(posedge CLK);
  endtask
  task automatic acc(input logic [31:0] cmd, input logic [3:0] es, input logic [1:0] ec,
    input int ml);
    wb(`CMD_OFS, 1'b1, cmd);
    for (int n = 0; n < 40; n++) begin
      wb(`STAT_OFS, 1'b0, 32'h0);
      if (q[0] === 1'b0) break;
    end
    `CHK("done", 1'b0, q[0])
    `CHK("strobes", es, strb)
    `CHK("enables", ec, ces)
    `CHK("low_len", 1'b1, last_len >= ml)
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    wb(`CTRL_OFS, 1'b0, 32'h0);
    `CHK("ctrl_rst", 32'h08, q)
    `CHK("rst_oe", 1'b0, CARD_RESET_OE)
    wb(4'h2, 1'b1, 32'hFF);
    wb(4'h2, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, q)
    wb(`CTRL_OFS, 1'b1, ctl(2'h0, 2'h0, 1'b1, 1'b0));
    pins(4'b1100);
    `CHK("reset_on", 2'b11, {CARD_RESET, CARD_RESET_OE})
    `CHK("ctl_oe", 1'b1, CTL_OE)
    wb(`STAT_OFS, 1'b0, 32'h0);
    `CHK("mem_stat", 4'b1111, {q[6], q[3:1]})
    pins(4'b1101);
    `CHK("absent", 1'b0, CARD_RESET_OE)
    wb(`CTRL_OFS, 1'b1, ctl(2'h0, 2'h0, 1'b0, 1'b0));
    pins(4'b0100);
    `CHK("reset_off", 1'b0, CARD_RESET)
    acc(32'h0001_1234, 4'b1011, 2'b00, 3);
    `CHK("d_oe_wr", 1'b1, doe_s)
    wait_len <= 4'h6;
    acc(32'h0, 4'b0111, 2'b00, 8);
    `CHK("d_oe_rd", 1'b0, doe_s)
    wait_len <= 4'h0;
    wb(`RDATA_OFS, 1'b0, 32'h0);
    `CHK("rdata16", 32'h1234, q)
    wb(`CTRL_OFS, 1'b1, ctl(socket_sig_pkg::MODE_IO, socket_sig_pkg::BFN_SPKR, 1'b0, 1'b1));
    pins(4'b1000);
    acc(32'h0006_0000, 4'b1101, 2'b01, 3);
    `CHK("a0", 1'b1, a0s)
    wb(`RDATA_OFS, 1'b0, 32'h0);
    `CHK("rdata8", 32'h34, q)
    `CHK("spkr", 1'b1, SPKR_OUT)
    wb(`STAT_OFS, 1'b0, 32'h0);
    `CHK("ireq", 1'b1, q[4])
    wb(`CTRL_OFS, 1'b1, ctl(socket_sig_pkg::MODE_IO, socket_sig_pkg::BFN_LED, 1'b0, 1'b0));
    pins(4'b0000);
    acc(32'h0003_00FF, 4'b1110, 2'b00, 3);
    `CHK("led", 1'b1, LED_OUT)
    wb(`STAT_OFS, 1'b0, 32'h0);
    `CHK("wide", 1'b1, q[11])
    wb(`RDATA_OFS, 1'b0, 32'h0);
    `CHK("rdata_keep", 32'h34, q)
    wb(`CTRL_OFS, 1'b1, ctl(socket_sig_pkg::MODE_CB, 2'h0, 1'b1, 1'b0));
    pins(4'b0010);
    `CHK("cb_pins", 2'b00, {CARD_RESET, CTL_OE})
    wb(`STAT_OFS, 1'b0, 32'h0);
    `CHK("cb_stat", 2'b11, {q[9], q[5]})
    `CHK("cb_type", 5'b01001, {q[15:12], q[1]})
    wb(`CMD_OFS, 1'b1, 32'h0001_0000);
    wb(`STAT_OFS, 1'b0, 32'h0);
    `CHK("cb_refuse", 1'b0, q[0])
    @(posedge CLK);
    c = CCLK;
    @(posedge CLK);
    `CHK("cclk_run", 1'b1, c ^ CCLK)
    pins(4'b1010);
    `CHK("cclk_stop", 1'b0, CCLK)
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
